// ### rtl/dsc_params.svh
/*
  Constants of the serial channel core: register offsets, field
  positions, reset values, status codes and 16X timing counts.
  Assumes it is included by bare name from rtl/ files only.
*/
`ifndef DSC_PARAMS_SVH
`define DSC_PARAMS_SVH

// ----------------------------------------------------------------
// Register offsets
// ----------------------------------------------------------------
`define DSC_ADDR_DATA      3'h0
`define DSC_ADDR_IER       3'h1
`define DSC_ADDR_ISR       3'h2
`define DSC_ADDR_LCR       3'h3
`define DSC_ADDR_MCR       3'h4
`define DSC_ADDR_LSR       3'h5
`define DSC_ADDR_MSR       3'h6
`define DSC_ADDR_SPR       3'h7

// ----------------------------------------------------------------
// Field positions
// ----------------------------------------------------------------
`define DSC_LCR_DLAB       7
`define DSC_LCR_BREAK      6
`define DSC_LCR_STICK      5
`define DSC_LCR_EVEN       4
`define DSC_LCR_PEN        3
`define DSC_LCR_STOP2      2
`define DSC_IER_RXD        0
`define DSC_IER_THRE       1
`define DSC_IER_LINE       2
`define DSC_IER_MODEM      3
`define DSC_MCR_DTR        0
`define DSC_MCR_RTS        1
`define DSC_MCR_OP2        3

// ----------------------------------------------------------------
// Reset values
// ----------------------------------------------------------------
`define DSC_LCR_RST        8'h00
`define DSC_IER_RST        4'h0
`define DSC_MCR_RST        5'h00
`define DSC_SPR_RST        8'hff
`define DSC_DLL_RST        8'h01
`define DSC_DLM_RST        8'h00

// ----------------------------------------------------------------
// Interrupt source codes
// ----------------------------------------------------------------
`define DSC_ISR_NONE       4'h1
`define DSC_ISR_LINE       4'h6
`define DSC_ISR_RXD        4'h4
`define DSC_ISR_THRE       4'h2
`define DSC_ISR_MODEM      4'h0

// ----------------------------------------------------------------
// 16X timing: centre and last tick of a bit; base of the last data bit index
// ----------------------------------------------------------------
`define DSC_TICK_MID       4'h7
`define DSC_TICK_LAST      4'hf
`define DSC_WORD_BASE      3'h4

`endif

// ### rtl/dsc_pkg.sv
/*
  Types of the serial channel core: transmitter and receiver states.
  Assumes nothing beyond a SystemVerilog compiler.
*/
package dsc_pkg;

  typedef enum logic [2:0] {
    TX_IDLE, TX_START, TX_DATA, TX_PARITY, TX_STOP
  } dsc_tx_state_type;

  typedef enum logic [2:0] {
    RX_IDLE, RX_START, RX_DATA, RX_PARITY, RX_STOP
  } dsc_rx_state_type;

endpackage : dsc_pkg

// ### rtl/dsc_rate_gen.sv
/*
  Rate generator: divides oscillator ticks by a 16-bit divisor and
  emits a one-cycle 16X enable pulse.
  Assumes osc_tick_i is a one-cycle pulse on clock_i and that the
  reset is already synchronised.
*/
`timescale 1ns/100ps
`include "dsc_params.svh"

module dsc_rate_gen (
  input  wire logic        clock_i,
  input  wire logic        rst_b_i,
  input  wire logic        osc_tick_i,
  input  wire logic [15:0] divisor_i,
  output logic             tick16_o
);

  logic [15:0] cnt_ff;
  logic [15:0] cnt_plus;
  logic        wrap;
  logic [15:0] nxt_cnt;
  logic        nxt_tick;
  logic        tick_ff;

  // A divisor of zero stops the 16X clock rather than wrapping
  assign cnt_plus = cnt_ff + 16'h0001;
  assign wrap     = (cnt_plus >= divisor_i);
  assign nxt_cnt  = !osc_tick_i ? cnt_ff : (wrap ? 16'h0000 : cnt_plus);
  assign nxt_tick = osc_tick_i & (divisor_i != 16'h0000) & wrap;

  always_ff @(posedge clock_i or negedge rst_b_i) begin
    if (!rst_b_i) begin
      cnt_ff  <= 16'h0000;
      tick_ff <= 1'b0;
    end else begin
      cnt_ff  <= nxt_cnt;
      tick_ff <= nxt_tick;
    end
  end

  assign tick16_o = tick_ff;

endmodule : dsc_rate_gen

// ### rtl/dsc_core.sv
/*
  One channel of a dual asynchronous serial controller: register file,
  transmitter, receiver, modem status and interrupt output.
  Assumes one 50 MHz clock, a register port with one-cycle strobes and
  an oscillator input of at most 24 MHz sampled as a plain pin.
*/
// Decided for this implementation: the register addresses and the strobed register port.
`timescale 1ns/100ps
`include "dsc_params.svh"

module dsc_core
  import dsc_pkg::*;
(
  input  wire logic       clock_i,
  input  wire logic       rst_b_i,
  input  wire logic [2:0] addr_i,
  input  wire logic [7:0] wdata_i,
  input  wire logic       wr_i,
  input  wire logic       rd_i,
  input  wire logic       rx_i,
  input  wire logic       osc_in_i,
  input  wire logic [3:0] modem_in_b_i,
  output logic      [7:0] rdata_o,
  output logic            tx_o,
  output logic            irq_o,
  output logic            osc_out_o,
  output logic            rts_b_o,
  output logic            dtr_b_o,
  output logic            op2_b_o
);

  // ----------------------------------------------------------------
  // Reset release and pin synchronisers
  // ----------------------------------------------------------------
  logic       rst_s1_ff;
  logic       rst_s2_ff;
  logic       rst_n;
  logic [2:0] osc_sync_ff;
  logic [2:0] rx_sync_ff;
  logic [3:0] mdm_s1_ff;
  logic [3:0] mdm_s2_ff;
  logic [3:0] mdm_prev_ff;

  always_ff @(posedge clock_i or negedge rst_b_i) begin
    if (!rst_b_i) begin
      rst_s1_ff <= 1'b0;
      rst_s2_ff <= 1'b0;
    end else begin
      rst_s1_ff <= 1'b1;
      rst_s2_ff <= rst_s1_ff;
    end
  end

  assign rst_n = rst_s2_ff;

  // Third stage only feeds edge detectors, never the first stage
  always_ff @(posedge clock_i or negedge rst_n) begin
    if (!rst_n) begin
      osc_sync_ff <= 3'h0;
      rx_sync_ff  <= 3'h7;
      mdm_s1_ff   <= 4'hf;
      mdm_s2_ff   <= 4'hf;
      mdm_prev_ff <= 4'hf;
    end else begin
      osc_sync_ff <= {osc_sync_ff[1:0], osc_in_i};
      rx_sync_ff  <= {rx_sync_ff[1:0], rx_i};
      mdm_s1_ff   <= modem_in_b_i;
      mdm_s2_ff   <= mdm_s1_ff;
      mdm_prev_ff <= mdm_s2_ff;
    end
  end

  // ----------------------------------------------------------------
  // Register file
  // ----------------------------------------------------------------
  logic [7:0] lcr_ff;
  logic [3:0] ier_ff;
  logic [4:0] mcr_ff;
  logic [7:0] spr_ff;
  logic [7:0] dll_ff;
  logic [7:0] dlm_ff;
  logic       dlab;
  logic       sel_data;
  logic       sel_ier;
  logic       wr_thr;
  logic       wr_dll;
  logic       wr_dlm;
  logic       wr_ier;
  logic       wr_lcr;
  logic       wr_mcr;
  logic       wr_spr;
  logic       rd_rhr;
  logic       rd_lsr;
  logic       rd_msr;

  assign dlab     = lcr_ff[`DSC_LCR_DLAB];
  assign sel_data = (addr_i == `DSC_ADDR_DATA);
  assign sel_ier  = (addr_i == `DSC_ADDR_IER);
  assign wr_thr   = wr_i & sel_data & ~dlab;
  assign wr_dll   = wr_i & sel_data & dlab;
  assign wr_dlm   = wr_i & sel_ier & dlab;
  assign wr_ier   = wr_i & sel_ier & ~dlab;
  assign wr_lcr   = wr_i & (addr_i == `DSC_ADDR_LCR);
  assign wr_mcr   = wr_i & (addr_i == `DSC_ADDR_MCR);
  assign wr_spr   = wr_i & (addr_i == `DSC_ADDR_SPR);
  assign rd_rhr   = rd_i & sel_data & ~dlab;
  assign rd_lsr   = rd_i & (addr_i == `DSC_ADDR_LSR);
  assign rd_msr   = rd_i & (addr_i == `DSC_ADDR_MSR);

  // Bus logic runs on the system clock, so no oscillator is needed
  always_ff @(posedge clock_i or negedge rst_n) begin
    if (!rst_n) begin
      lcr_ff <= `DSC_LCR_RST;
      ier_ff <= `DSC_IER_RST;
      mcr_ff <= `DSC_MCR_RST;
      spr_ff <= `DSC_SPR_RST;
      dll_ff <= `DSC_DLL_RST;
      dlm_ff <= `DSC_DLM_RST;
    end else begin
      if (wr_lcr) lcr_ff <= wdata_i;
      if (wr_ier) ier_ff <= wdata_i[3:0];
      if (wr_mcr) mcr_ff <= wdata_i[4:0];
      if (wr_spr) spr_ff <= wdata_i;
      if (wr_dll) dll_ff <= wdata_i;
      if (wr_dlm) dlm_ff <= wdata_i;
    end
  end

  // ----------------------------------------------------------------
  // Rate generator shared by both directions
  // ----------------------------------------------------------------
  logic osc_tick;
  logic tick16;

  // 24 MHz stays below half of the 50 MHz sampling clock
  assign osc_tick = osc_sync_ff[1] & ~osc_sync_ff[2];

  dsc_rate_gen u_rate_generator (
    .clock_i    (clock_i),
    .rst_b_i    (rst_n),
    .osc_tick_i (osc_tick),
    .divisor_i  ({dlm_ff, dll_ff}),
    .tick16_o   (tick16)
  );

  // ----------------------------------------------------------------
  // Frame format shared by transmitter and receiver
  // ----------------------------------------------------------------
  logic [2:0] word_last;
  logic       par_en;

  assign word_last = `DSC_WORD_BASE + {1'b0, lcr_ff[1:0]};
  assign par_en    = lcr_ff[`DSC_LCR_PEN];

  function automatic logic par_bit(input logic acc, input logic [7:0] l);
    par_bit = l[`DSC_LCR_STICK] ? ~l[`DSC_LCR_EVEN]
                                : (l[`DSC_LCR_EVEN] ? acc : ~acc);
  endfunction : par_bit

  // ----------------------------------------------------------------
  // Transmitter
  // ----------------------------------------------------------------
  dsc_tx_state_type tx_state_ff;
  dsc_tx_state_type nxt_tx_state;
  logic [7:0] tx_holding_reg_ff;
  logic       thr_full_ff;
  logic [7:0] tx_shifter_ff;
  logic [3:0] tx_cnt_ff;
  logic [2:0] tx_bit_ff;
  logic       tx_par_ff;
  logic       tx_line_ff;
  logic       tx_end;
  logic       tx_load;
  logic       tx_chg;
  logic       nxt_tx_line;

  assign tx_end  = tick16 & (tx_cnt_ff == `DSC_TICK_LAST);
  assign tx_load = (tx_state_ff == TX_IDLE) & thr_full_ff;
  assign tx_chg  = (nxt_tx_state != tx_state_ff);

  always_comb begin
    nxt_tx_state = tx_state_ff;
    case (tx_state_ff)
      TX_IDLE:   if (thr_full_ff) nxt_tx_state = TX_START;
      TX_START:  if (tx_end) nxt_tx_state = TX_DATA;
      TX_DATA:   if (tx_end && tx_bit_ff == word_last)
                   nxt_tx_state = par_en ? TX_PARITY : TX_STOP;
      TX_PARITY: if (tx_end) nxt_tx_state = TX_STOP;
      TX_STOP:   if (tx_end && (!lcr_ff[`DSC_LCR_STOP2] ||
                                tx_bit_ff == 3'h1))
                   nxt_tx_state = TX_IDLE;
      default:   nxt_tx_state = TX_IDLE;
    endcase
  end

  // Break holds the line low without disturbing the frame timing
  assign nxt_tx_line = lcr_ff[`DSC_LCR_BREAK] ? 1'b0 :
                       (tx_state_ff == TX_START)  ? 1'b0 :
                       (tx_state_ff == TX_DATA)   ? tx_shifter_ff[0] :
                       (tx_state_ff == TX_PARITY) ?
                         par_bit(tx_par_ff, lcr_ff) : 1'b1;

  // A write in the load cycle refills the holding stage at once
  always_ff @(posedge clock_i or negedge rst_n) begin
    if (!rst_n) begin
      tx_holding_reg_ff <= 8'h00;
      thr_full_ff       <= 1'b0;
    end else if (wr_thr) begin
      tx_holding_reg_ff <= wdata_i;
      thr_full_ff       <= 1'b1;
    end else if (tx_load) begin
      thr_full_ff       <= 1'b0;
    end
  end

  always_ff @(posedge clock_i or negedge rst_n) begin
    if (!rst_n) begin
      tx_state_ff <= TX_IDLE;
      tx_line_ff  <= 1'b1;
      tx_cnt_ff   <= 4'h0;
      tx_bit_ff   <= 3'h0;
    end else begin
      tx_state_ff <= nxt_tx_state;
      tx_line_ff  <= nxt_tx_line;
      tx_cnt_ff   <= (tx_state_ff == TX_IDLE) ? 4'h0
                                              : tx_cnt_ff + {3'h0, tick16};
      tx_bit_ff   <= tx_chg ? 3'h0 : tx_bit_ff + {2'h0, tx_end};
    end
  end

  always_ff @(posedge clock_i or negedge rst_n) begin
    if (!rst_n) begin
      tx_shifter_ff <= 8'h00;
      tx_par_ff     <= 1'b0;
    end else if (tx_load) begin
      tx_shifter_ff <= tx_holding_reg_ff;
      tx_par_ff     <= 1'b0;
    end else if (tx_end && tx_state_ff == TX_DATA) begin
      tx_shifter_ff <= {1'b0, tx_shifter_ff[7:1]};
      tx_par_ff     <= tx_par_ff ^ tx_shifter_ff[0];
    end
  end

  // ----------------------------------------------------------------
  // Receiver
  // ----------------------------------------------------------------
  dsc_rx_state_type rx_state_ff;
  dsc_rx_state_type nxt_rx_state;
  logic       rx_in;
  logic       rx_fall;
  logic [3:0] rx_cnt_ff;
  logic [2:0] rx_bit_ff;
  logic [7:0] rx_shifter_ff;
  logic       rx_par_ff;
  logic       rx_mark_ff;
  logic       rx_pe_ff;
  logic       rx_mid;
  logic       rx_end;
  logic       rx_chg;
  logic       rx_done;
  logic       rx_accept;
  logic [7:0] rx_holding_reg_ff;
  logic [2:0] rx_tags_ff;
  logic       data_ready_ff;
  logic       overrun_ff;

  assign rx_in   = rx_sync_ff[1];
  assign rx_fall = rx_sync_ff[2] & ~rx_in;
  assign rx_mid  = tick16 & (rx_cnt_ff == `DSC_TICK_MID);
  assign rx_end  = tick16 & (rx_cnt_ff == `DSC_TICK_LAST);
  assign rx_chg  = (nxt_rx_state != rx_state_ff);

  always_comb begin
    nxt_rx_state = rx_state_ff;
    case (rx_state_ff)
      RX_IDLE:   if (rx_fall) nxt_rx_state = RX_START;
      RX_START:  if (rx_mid)
                   nxt_rx_state = rx_in ? RX_IDLE : RX_DATA;
      RX_DATA:   if (rx_end && rx_bit_ff == word_last)
                   nxt_rx_state = par_en ? RX_PARITY : RX_STOP;
      RX_PARITY: if (rx_end) nxt_rx_state = RX_STOP;
      RX_STOP:   if (rx_end) nxt_rx_state = RX_IDLE;
      default:   nxt_rx_state = RX_IDLE;
    endcase
  end

  // Counter restarts on each state change, so the centre is kept
  always_ff @(posedge clock_i or negedge rst_n) begin
    if (!rst_n) begin
      rx_state_ff <= RX_IDLE;
      rx_cnt_ff   <= 4'h0;
      rx_bit_ff   <= 3'h0;
    end else begin
      rx_state_ff <= nxt_rx_state;
      rx_cnt_ff   <= (rx_chg || rx_state_ff == RX_IDLE) ? 4'h0
                     : rx_cnt_ff + {3'h0, tick16};
      rx_bit_ff   <= rx_chg ? 3'h0 : rx_bit_ff + {2'h0, rx_end};
    end
  end

  always_ff @(posedge clock_i or negedge rst_n) begin
    if (!rst_n) begin
      rx_shifter_ff <= 8'h00;
      rx_par_ff     <= 1'b0;
      rx_mark_ff    <= 1'b0;
      rx_pe_ff      <= 1'b0;
    end else if (rx_state_ff == RX_START) begin
      rx_shifter_ff <= 8'h00;
      rx_par_ff     <= 1'b0;
      rx_mark_ff    <= 1'b0;
      rx_pe_ff      <= 1'b0;
    end else if (rx_end && rx_state_ff == RX_DATA) begin
      rx_shifter_ff[rx_bit_ff] <= rx_in;
      rx_par_ff     <= rx_par_ff ^ rx_in;
      rx_mark_ff    <= rx_mark_ff | rx_in;
    end else if (rx_end && rx_state_ff == RX_PARITY) begin
      rx_pe_ff      <= (rx_in != par_bit(rx_par_ff, lcr_ff));
      rx_mark_ff    <= rx_mark_ff | rx_in;
    end
  end

  // ----------------------------------------------------------------
  // Receive holding stage: byte plus three error tags
  // ----------------------------------------------------------------
  // A read in the completion cycle frees the stage for the new byte
  assign rx_done   = rx_end & (rx_state_ff == RX_STOP);
  assign rx_accept = rx_done & (~data_ready_ff | rd_rhr);

  always_ff @(posedge clock_i or negedge rst_n) begin
    if (!rst_n) begin
      rx_holding_reg_ff <= 8'h00;
      rx_tags_ff        <= 3'h0;
      data_ready_ff     <= 1'b0;
    end else if (rx_accept) begin
      rx_holding_reg_ff <= rx_shifter_ff;
      rx_tags_ff        <= {~(rx_mark_ff | rx_in), ~rx_in, rx_pe_ff};
      data_ready_ff     <= 1'b1;
    end else if (rd_rhr) begin
      rx_tags_ff        <= 3'h0;
      data_ready_ff     <= 1'b0;
    end
  end

  // Overrun set wins over the clear caused by a status read
  always_ff @(posedge clock_i or negedge rst_n) begin
    if (!rst_n) overrun_ff <= 1'b0;
    else overrun_ff <= (rx_done & data_ready_ff & ~rd_rhr) |
                       (overrun_ff & ~rd_lsr);
  end

  // ----------------------------------------------------------------
  // Modem status with change flags
  // ----------------------------------------------------------------
  logic [3:0] delta_ff;

  always_ff @(posedge clock_i or negedge rst_n) begin
    if (!rst_n) delta_ff <= 4'h0;
    else delta_ff <= (mdm_s2_ff ^ mdm_prev_ff) | (delta_ff & ~{4{rd_msr}});
  end

  // ----------------------------------------------------------------
  // Status, interrupt source and read data
  // ----------------------------------------------------------------
  logic       thr_empty;
  logic       tx_all_empty;
  logic [7:0] line_status;
  logic [7:0] modem_status;
  logic       line_irq;
  logic       rxd_irq;
  logic       thre_irq;
  logic       modem_irq;
  logic [3:0] irq_source;
  logic [7:0] rd_mux;
  logic [7:0] rdata_ff;
  logic       irq_ff;
  logic       osc_out_ff;
  logic       dtr_b_ff;
  logic       rts_b_ff;
  logic       op2_b_ff;

  assign thr_empty    = ~thr_full_ff;
  assign tx_all_empty = thr_empty & (tx_state_ff == TX_IDLE);
  assign line_status  = {1'b0, tx_all_empty, thr_empty, rx_tags_ff,
                         overrun_ff, data_ready_ff};
  assign modem_status = {~mdm_s2_ff, delta_ff};

  assign line_irq  = ier_ff[`DSC_IER_LINE] & (overrun_ff | |rx_tags_ff);
  assign rxd_irq   = ier_ff[`DSC_IER_RXD] & data_ready_ff;
  assign thre_irq  = ier_ff[`DSC_IER_THRE] & thr_empty;
  assign modem_irq = ier_ff[`DSC_IER_MODEM] & |delta_ff;

  assign irq_source = line_irq  ? `DSC_ISR_LINE  :
                      rxd_irq   ? `DSC_ISR_RXD   :
                      thre_irq  ? `DSC_ISR_THRE  :
                      modem_irq ? `DSC_ISR_MODEM : `DSC_ISR_NONE;

  assign rd_mux =
    (addr_i == `DSC_ADDR_DATA) ? (dlab ? dll_ff : rx_holding_reg_ff) :
    (addr_i == `DSC_ADDR_IER)  ? (dlab ? dlm_ff : {4'h0, ier_ff})    :
    (addr_i == `DSC_ADDR_ISR)  ? {4'h0, irq_source}                   :
    (addr_i == `DSC_ADDR_LCR)  ? lcr_ff                               :
    (addr_i == `DSC_ADDR_MCR)  ? {3'h0, mcr_ff}                       :
    (addr_i == `DSC_ADDR_LSR)  ? line_status                          :
    (addr_i == `DSC_ADDR_MSR)  ? modem_status : spr_ff;

  always_ff @(posedge clock_i or negedge rst_n) begin
    if (!rst_n) begin
      rdata_ff   <= 8'h00;
      irq_ff     <= 1'b0;
      osc_out_ff <= 1'b0;
      dtr_b_ff   <= 1'b1;
      rts_b_ff   <= 1'b1;
      op2_b_ff   <= 1'b1;
    end else begin
      rdata_ff   <= rd_i ? rd_mux : 8'h00;
      irq_ff     <= (irq_source != `DSC_ISR_NONE);
      osc_out_ff <= ~osc_sync_ff[1];
      dtr_b_ff   <= ~mcr_ff[`DSC_MCR_DTR];
      rts_b_ff   <= ~mcr_ff[`DSC_MCR_RTS];
      op2_b_ff   <= ~mcr_ff[`DSC_MCR_OP2];
    end
  end

  assign rdata_o   = rdata_ff;
  assign tx_o      = tx_line_ff;
  assign irq_o     = irq_ff;
  assign osc_out_o = osc_out_ff;
  assign dtr_b_o   = dtr_b_ff;
  assign rts_b_o   = rts_b_ff;
  assign op2_b_o   = op2_b_ff;

endmodule : dsc_core

// ### sim/dsc_core_assertions.sv
/* Port checker of one serial channel.
   Assumes one-cycle strobes and a raw active-low reset. */
`timescale 1ns/100ps
module dsc_core_assertions (
  input  wire logic       clock_i,
  input  wire logic       rst_b_i,
  input  wire logic [2:0] addr_i,
  input  wire logic [7:0] wdata_i,
  input  wire logic       wr_i,
  input  wire logic       rd_i,
  input  wire logic [7:0] rdata_o,
  input  wire logic       tx_o,
  input  wire logic       irq_o,
  input  wire logic       rts_b_o
);
  // ------------------------------------------------------------
  // Shadow control bits
  // ------------------------------------------------------------
  logic       dlab_ff;
  logic       brk_ff;
  logic       rts_ff;
  logic [3:0] ier_ff;
  wire        lcr_wr = wr_i && addr_i == 3'h3;
  wire        ier_wr = wr_i && addr_i == 3'h1 && !dlab_ff;
  wire        mcr_wr = wr_i && addr_i == 3'h4;
  always_ff @(posedge clock_i or negedge rst_b_i) begin
    if (!rst_b_i) begin
      dlab_ff <= 1'b0;
      brk_ff  <= 1'b0;
      rts_ff  <= 1'b0;
      ier_ff  <= 4'h0;
    end else begin
      if (lcr_wr) dlab_ff <= wdata_i[7];
      if (lcr_wr) brk_ff <= wdata_i[6];
      if (mcr_wr) rts_ff <= wdata_i[1];
      if (ier_wr) ier_ff <= wdata_i[3:0];
    end
  end
  // ------------------------------------------------------------
  // Properties
  // ------------------------------------------------------------
  default clocking cb @(posedge clock_i); endclocking
  default disable iff (!rst_b_i);
  sequence s_spr;
    wr_i && addr_i == 3'h7 ##1 !wr_i ##1 rd_i && addr_i == 3'h7;
  endsequence
  sequence s_div;
    dlab_ff && wr_i && addr_i == 3'h0 ##1 !wr_i ##1 rd_i && addr_i == 3'h0;
  endsequence
  AST_SPR_READBACK: assert property (
    s_spr |=> rdata_o == $past(wdata_i, 3)) else $error("scratch lost");
  AST_DIV_READBACK: assert property (
    s_div |=> rdata_o == $past(wdata_i, 3)) else $error("divisor lost");
  AST_RDATA_ZERO: assert property (
    !$past(rd_i) |-> rdata_o == 8'h00) else $error("stray read data");
  AST_LSR_TEMT: assert property (
    rd_i && addr_i == 3'h5 |=> !rdata_o[6] || rdata_o[5])
    else $error("shifter empty with holding full");
  AST_ISR_IRQ: assert property (
    rd_i && addr_i == 3'h2 |=> irq_o == (rdata_o[3:0] != 4'h1))
    else $error("irq disagrees with source");
  AST_IER_QUIET: assert property (
    ier_ff == 4'h0 && $past(ier_ff) == 4'h0 |-> !irq_o)
    else $error("irq while all disabled");
  AST_BREAK_LOW: assert property (
    brk_ff && $past(brk_ff) |-> !tx_o) else $error("break not low");
  AST_RTS_FOLLOW: assert property (
    rts_ff == $past(rts_ff) |-> rts_b_o == !rts_ff)
    else $error("rts out of step");
endmodule : dsc_core_assertions

bind dsc_core dsc_core_assertions u_dsc_core_assertions (
  .clock_i, .rst_b_i, .addr_i, .wdata_i, .wr_i, .rd_i,
  .rdata_o, .tx_o, .irq_o, .rts_b_o
);

// ### sim/dsc_serial_peer.sv
/* Remote serial device: drives the receive line, samples transmit.
   Assumes its tasks are called just after a rising clock edge. */
`timescale 1ns/100ps
module dsc_serial_peer #(
  parameter int BIT_CLKS = 64
) (
  input  wire logic clock_i,
  input  wire logic tx_i,
  output logic      rx_o
);
  initial rx_o = 1'b1;
  // Caller builds the frame; line idles high after it
  task automatic send(input logic [10:0] bits, input int n);
    for (int i = 0; i < n; i++) begin
      rx_o <= bits[i];
      repeat (BIT_CLKS) @(posedge clock_i);
    end
    rx_o <= 1'b1;
  endtask : send
  // Entered at a start edge; stops at the last centre for back-to-back
  task automatic recv(output logic [10:0] bits, input int n,
                      input int bc);
    bits = '1;
    repeat (bc / 2) @(posedge clock_i);
    for (int i = 0; i < n; i++) begin
      bits[i] = tx_i;
      if (i < n - 1) repeat (bc) @(posedge clock_i);
    end
  endtask : recv
  // Low pulse far shorter than half a bit
  task automatic glitch();
    rx_o <= 1'b0;
    repeat (8) @(posedge clock_i);
    rx_o <= 1'b1;
  endtask : glitch
endmodule : dsc_serial_peer

// ### sim/dsc_core_tb_top.sv
/* Self-checking bench of one serial channel.
   Assumes the checker is bound and the peer sits on the serial pins. */
`timescale 1ns/100ps
module dsc_core_tb_top;
  logic        clock_i = 1'b0;
  logic        rst_b_i = 1'b0;
  logic [2:0]  addr_i = 3'h0;
  logic [7:0]  wdata_i = 8'h00;
  logic        wr_i = 1'b0;
  logic        rd_i = 1'b0;
  logic        osc_in_i = 1'b0;
  logic [1:0]  osc_cnt = 2'h0;
  logic        rx_i;
  logic [7:0]  rdata_o;
  logic        tx_o;
  logic        irq_o;
  logic        rts_b_o;
  logic        dtr_b_o;
  logic        op2_b_o;
  logic        osc_out_o;
  logic        osc_seen;
  logic [10:0] got;
  int          failures = 0;
  int          checks = 0;
  logic [18:0] rows [10] = '{
    {3'h7, 8'h5a, 8'h5a}, {3'h4, 8'h0b, 8'h0b}, {3'h3, 8'h83, 8'h83},
    {3'h0, 8'h34, 8'h34}, {3'h1, 8'h12, 8'h12}, {3'h3, 8'h03, 8'h03},
    {3'h1, 8'h0f, 8'h0f}, {3'h2, 8'hff, 8'h02}, {3'h5, 8'h00, 8'h60},
    {3'h1, 8'h00, 8'h00}};
  always #10 clock_i = ~clock_i;
  // 12.5 MHz oscillator, inside the 24 MHz ceiling
  always @(posedge clock_i) begin
    osc_cnt  <= osc_cnt + 2'h1;
    osc_in_i <= osc_cnt[1];
  end
  dsc_core u_dsc_core (.clock_i, .rst_b_i, .addr_i, .wdata_i, .wr_i,
    .rd_i, .rx_i, .osc_in_i, .modem_in_b_i(4'hf), .rdata_o, .tx_o,
    .irq_o, .osc_out_o, .rts_b_o, .dtr_b_o, .op2_b_o);
  dsc_serial_peer u_dsc_serial_peer (.clock_i, .tx_i(tx_o), .rx_o(rx_i));
  // ------------------------------------------------------------
  // Tasks
  // ------------------------------------------------------------
  task automatic final_report();
    if (failures == 0 && checks > 0) begin
      $display("All checks passed");
    end else begin
      $display("Checks failed");
    end
    $finish;
  endtask : final_report
  task automatic chk(input logic [10:0] g, input logic [10:0] e);
    checks++;
    if (g !== e) begin
      failures++;
      $display("[FAIL] %0t got %h exp %h", $time, g, e);
    end
  endtask : chk
  task automatic wr(input logic [2:0] a, input logic [7:0] d);
    @(posedge clock_i);
    addr_i  <= a;
    wdata_i <= d;
    wr_i    <= 1'b1;
    @(posedge clock_i);
    wr_i    <= 1'b0;
  endtask : wr
  task automatic rd(input logic [2:0] a, input logic [7:0] e);
    @(posedge clock_i);
    addr_i <= a;
    rd_i   <= 1'b1;
    @(posedge clock_i);
    rd_i   <= 1'b0;
    #1;
    chk({3'h0, rdata_o}, {3'h0, e});
  endtask : rd
  task automatic wait_for(input bit use_tx, input logic v);
    for (int i = 0; i < 3000; i++) begin
      @(posedge clock_i);
      #1;
      if ((use_tx ? tx_o : irq_o) === v) return;
    end
    failures++;
    final_report();
  endtask : wait_for
  task automatic tx_frame(input int n, input int bc, input logic [10:0] e);
    wait_for(1'b1, 1'b0);
    u_dsc_serial_peer.recv(got, n, bc);
    chk(got, e);
  endtask : tx_frame
  task automatic rx_case(input logic [7:0] line_control_reg, input logic [10:0] b,
      input int n, input logic [7:0] line_status_reg, input logic [7:0] rx_holding_reg);
    wr(3'h3, line_control_reg);
    u_dsc_serial_peer.send(b, n);
    wait_for(1'b0, 1'b1);
    rd(3'h5, line_status_reg);
    rd(3'h0, rx_holding_reg);
    rd(3'h5, 8'h60);
    chk({10'h0, irq_o}, 11'h0);
  endtask : rx_case
  // ------------------------------------------------------------
  // Sequence
  // ------------------------------------------------------------
  initial begin
    repeat (3) @(posedge clock_i);
    rst_b_i <= 1'b1;
    repeat (3) @(posedge clock_i);
    foreach (rows[i]) begin
      wr(rows[i][18:16], rows[i][15:8]);
      rd(rows[i][18:16], rows[i][7:0]);
    end
    chk({8'h0, rts_b_o, dtr_b_o, op2_b_o}, 11'h0);
    rst_b_i <= 1'b0;
    repeat (3) @(posedge clock_i);
    rst_b_i <= 1'b1;
    repeat (3) @(posedge clock_i);
    rd(3'h7, 8'hff);
    chk({8'h0, rts_b_o, dtr_b_o, op2_b_o}, 11'h7);
    osc_seen = osc_out_o;
    repeat (2) @(posedge clock_i);
    #1;
    chk({10'h0, osc_out_o}, {10'h0, ~osc_seen});
    wr(3'h3, 8'h80);
    rd(3'h0, 8'h01);
    rd(3'h1, 8'h00);
    wr(3'h3, 8'h03);
    wr(3'h1, 8'h02);
    wait_for(1'b0, 1'b1);
    rd(3'h2, 8'h02);
    wr(3'h0, 8'ha5);
    rd(3'h5, 8'h20);
    wr(3'h0, 8'h3c);
    rd(3'h5, 8'h00);
    chk({10'h0, irq_o}, 11'h0);
    tx_frame(10, 64, {2'b11, 8'ha5, 1'b0});
    tx_frame(10, 64, {2'b11, 8'h3c, 1'b0});
    repeat (40) @(posedge clock_i);
    rd(3'h5, 8'h60);
    wr(3'h3, 8'h1e);
    wr(3'h0, 8'h4b);
    tx_frame(11, 64, {2'b11, 1'b0, 7'h4b, 1'b0});
    repeat (100) @(posedge clock_i);
    wr(3'h3, 8'h83);
    wr(3'h0, 8'h02);
    wr(3'h3, 8'h03);
    wr(3'h0, 8'h96);
    tx_frame(10, 128, {2'b11, 8'h96, 1'b0});
    repeat (100) @(posedge clock_i);
    wr(3'h3, 8'h83);
    wr(3'h0, 8'h01);
    wr(3'h3, 8'h43);
    repeat (4) @(posedge clock_i);
    chk({10'h0, tx_o}, 11'h0);
    wr(3'h1, 8'h01);
    rx_case(8'h03, 11'h278, 10, 8'h61, 8'h3c);
    rx_case(8'h03, 11'h102, 10, 8'h69, 8'h81);
    rx_case(8'h1b, 11'h402, 11, 8'h65, 8'h01);
    rx_case(8'h1b, 11'h406, 11, 8'h61, 8'h03);
    rx_case(8'h03, 11'h000, 10, 8'h79, 8'h00);
    wr(3'h3, 8'h03);
    u_dsc_serial_peer.send(11'h222, 10);
    @(posedge clock_i);
    u_dsc_serial_peer.send(11'h244, 10);
    rd(3'h5, 8'h63);
    rd(3'h0, 8'h11);
    u_dsc_serial_peer.glitch();
    repeat (200) @(posedge clock_i);
    rd(3'h5, 8'h60);
    final_report();
  end
endmodule : dsc_core_tb_top
